/* core/iaf_fifo.sv */
`timescale 1ns/1ns
module iaf_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0]  wp_ff;
  logic [AW:0]  rp_ff;
  logic [AW:0]  nxt_wp;
  logic [AW:0]  nxt_rp;
  logic         full;
  logic         empty;

  // ----------------------------------------------------------------
  // Pointer control
  // ----------------------------------------------------------------
  // Extra pointer bit tells full from empty without a counter
  assign full      = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
  assign empty     = (wp_ff == rp_ff);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_ff[rp_ff[AW-1:0]];

  always_comb begin
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    if (in_valid && !full) begin
      nxt_wp = wp_ff + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_rp = rp_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
    end
  end

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      mem_ff[wp_ff[AW-1:0]] <= in_data;
    end
  end
endmodule

/* core/iaf_filter.sv */
`timescale 1ns/1ns
module iaf_filter import iaf_pkg::*; #(
  parameter int N        = NUM_INPUTS,
  parameter int CYC_SLOW = CONV_CYC_DEFAULT,
  parameter int CYC_FAST = CONV_CYC_FAST
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  host_wr,
  input  wire logic                  host_rd,
  input  wire logic [4:0]            host_addr,
  input  wire logic [15:0]           host_wdata,
  output logic [15:0]                host_rdata,
  input  wire logic                  unit_restart,
  input  wire logic [N-1:0]          peak_hold,
  output logic                       conv_req,
  output logic [2:0]                 conv_chan,
  output logic                       conv_fast,
  output logic [13:0]                full_scale,
  input  wire logic                  s_valid,
  output logic                       s_ready,
  input  wire logic [2:0]            s_chan,
  input  wire logic [SAMPLE_W-1:0]   s_data,
  input  wire logic                  s_broken,
  output logic [N*SAMPLE_W-1:0]      conv_words,
  output logic [N-1:0]               disc_flags
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Log2 of depth, zero meaning no averaging; unknown codes fall back to 2
  // depth code decode
  function automatic logic [2:0] lg_of(input logic [15:0] code);
    case (code)
      DEPTH_CODE_NONE: lg_of = 3'h0;
      DEPTH_CODE_4:    lg_of = 3'h2;
      DEPTH_CODE_8:    lg_of = 3'h3;
      DEPTH_CODE_16:   lg_of = 3'h4;
      DEPTH_CODE_32:   lg_of = 3'h5;
      DEPTH_CODE_64:   lg_of = 3'h6;
      default:         lg_of = 3'h1;
    endcase
  endfunction

  // Arithmetic shift floors toward minus infinity
  function automatic logic [SAMPLE_W-1:0] mean_of(input logic signed [SUM_W-1:0] s,
                                                  input logic [2:0] lg);
    logic signed [SUM_W-1:0] q;
    q = s >>> lg;
    mean_of = q[SAMPLE_W-1:0];
  endfunction

  // ----------------------------------------------------------------
  // Setup words: shadow copies and active copies
  // ----------------------------------------------------------------
  logic [15:0] sh_en_ff;
  logic [15:0] sh_rate_ff;
  logic [15:0] sh_depth_ff [N];
  logic [15:0] act_en_ff;
  logic        act_fast_ff;
  logic [15:0] act_depth_ff [N];
  logic [15:0] nxt_sh_en;
  logic [15:0] nxt_sh_rate;
  logic [15:0] nxt_sh_depth [N];
  logic [15:0] nxt_act_en;
  logic        nxt_act_fast;
  logic [15:0] nxt_act_depth [N];
  logic [15:0] nxt_rdata;
  logic [15:0] host_rdata_ff;

  // Host writes land in the shadow; the filter only sees the active copy
  always_comb begin
    nxt_sh_en    = sh_en_ff;
    nxt_sh_rate  = sh_rate_ff;
    nxt_sh_depth = sh_depth_ff;
    nxt_act_en   = act_en_ff;
    nxt_act_fast = act_fast_ff;
    nxt_act_depth = act_depth_ff;
    nxt_rdata    = host_rdata_ff;
    if (host_wr) begin
      if (host_addr == OFS_INPUT_EN) begin
        nxt_sh_en = host_wdata;
      end else if (host_addr >= OFS_DEPTH_BASE && host_addr <= OFS_DEPTH_LAST) begin
        nxt_sh_depth[3'(host_addr - OFS_DEPTH_BASE)] = host_wdata;
      end else if (host_addr == OFS_RATE_CFG) begin
        nxt_sh_rate = host_wdata;
      end
    end
    if (host_rd) begin
      if (host_addr == OFS_INPUT_EN) begin
        nxt_rdata = sh_en_ff;
      end else if (host_addr >= OFS_DEPTH_BASE && host_addr <= OFS_DEPTH_LAST) begin
        nxt_rdata = sh_depth_ff[3'(host_addr - OFS_DEPTH_BASE)];
      end else if (host_addr == OFS_RATE_CFG) begin
        nxt_rdata = sh_rate_ff;
      end else begin
        nxt_rdata = 16'h0000;
      end
    end
    if (unit_restart) begin
      nxt_act_en    = sh_en_ff;
      nxt_act_depth = sh_depth_ff;
      nxt_act_fast  = (sh_rate_ff[RATE_FIELD_MSB:RATE_FIELD_LSB] == RATE_FAST_CODE);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_en_ff      <= RST_INPUT_EN;
      sh_rate_ff    <= RST_RATE_CFG;
      act_en_ff     <= RST_INPUT_EN;
      act_fast_ff   <= 1'b0;
      host_rdata_ff <= 16'h0000;
      for (int i = 0; i < N; i++) begin
        sh_depth_ff[i]  <= RST_DEPTH;
        act_depth_ff[i] <= RST_DEPTH;
      end
    end else begin
      sh_en_ff      <= nxt_sh_en;
      sh_rate_ff    <= nxt_sh_rate;
      sh_depth_ff   <= nxt_sh_depth;
      act_en_ff     <= nxt_act_en;
      act_fast_ff   <= nxt_act_fast;
      act_depth_ff  <= nxt_act_depth;
      host_rdata_ff <= nxt_rdata;
    end
  end
  assign host_rdata = host_rdata_ff;

  // ----------------------------------------------------------------
  // Conversion scan sequencer
  // ----------------------------------------------------------------
  logic [15:0] tmr_ff;
  logic [2:0]  rr_ff;
  logic        req_ff;
  logic [2:0]  chan_ff;
  logic [15:0] nxt_tmr;
  logic [2:0]  nxt_rr;
  logic        nxt_req;
  logic [2:0]  nxt_chan;
  logic        found;
  logic [2:0]  pick;

  always_comb begin
    nxt_tmr  = tmr_ff;
    nxt_rr   = rr_ff;
    nxt_req  = 1'b0;
    nxt_chan = chan_ff;
    found    = 1'b0;
    pick     = rr_ff;
    for (int k = 1; k <= N; k++) begin
      if (!found && act_en_ff[3'(rr_ff + 3'(k))]) begin
        found = 1'b1;
        pick  = 3'(rr_ff + 3'(k));
      end
    end
    if (unit_restart) begin
      nxt_tmr = 16'h0000;
      nxt_rr  = 3'(N - 1);
    end else if (tmr_ff != 16'h0000) begin
      nxt_tmr = tmr_ff - 16'h0001;
    end else begin
      // Period counts from the request, so the scan never drifts
      nxt_tmr = act_fast_ff ? 16'(CYC_FAST - 1) : 16'(CYC_SLOW - 1);
      if (found) begin
        nxt_req  = 1'b1;
        nxt_chan = pick;
        nxt_rr   = pick;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff  <= 16'h0000;
      rr_ff   <= 3'(N - 1);
      req_ff  <= 1'b0;
      chan_ff <= 3'h0;
    end else begin
      tmr_ff  <= nxt_tmr;
      rr_ff   <= nxt_rr;
      req_ff  <= nxt_req;
      chan_ff <= nxt_chan;
    end
  end
  assign conv_req   = req_ff;
  assign conv_chan  = chan_ff;
  assign conv_fast  = act_fast_ff;
  assign full_scale = act_fast_ff ? FULL_SCALE_FAST : FULL_SCALE_DEFAULT;

  // ----------------------------------------------------------------
  // Sample FIFO and history memory
  // ----------------------------------------------------------------
  logic                f_valid;
  logic                f_ready;
  logic [19:0]         f_data;
  logic                mem_we;
  logic [8:0]          mem_wa;
  logic [8:0]          mem_ra;
  logic [SAMPLE_W-1:0] mem_rd;
  logic [SAMPLE_W-1:0] smp_ff;

  iaf_fifo #(.W(20), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (s_valid),
    .in_ready  (s_ready),
    .in_data   ({s_broken, s_chan, s_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  iaf_hist_mem #(.W(SAMPLE_W), .AW(9)) u_hist (
    .clk     (clk),
    .wr_en   (mem_we),
    .wr_addr (mem_wa),
    .wr_data (smp_ff),
    .rd_addr (mem_ra),
    .rd_data (mem_rd)
  );

  // ----------------------------------------------------------------
  // Averaging engine
  // ----------------------------------------------------------------
  iaf_state_t              st_ff;
  iaf_state_t              nxt_st;
  logic [2:0]              ch_ff;
  logic                    brk_ff;
  logic [5:0]              pcnt_ff;
  logic [5:0]              nxt_pcnt;
  logic [SAMPLE_W-1:0]     nxt_smp;
  logic [2:0]              nxt_ch;
  logic                    nxt_brk;
  logic [5:0]              ptr_ff [N];
  logic [5:0]              nxt_ptr [N];
  logic signed [SUM_W-1:0] sum_ff [N];
  logic signed [SUM_W-1:0] nxt_sum [N];
  logic [SAMPLE_W-1:0]     out_ff [N];
  logic [SAMPLE_W-1:0]     nxt_out [N];
  logic [N-1:0]            primed_ff;
  logic [N-1:0]            nxt_primed;
  logic [N-1:0]            disc_ff;
  logic [N-1:0]            nxt_disc;
  logic [2:0]              lg;
  logic [5:0]              dmask;
  logic signed [SUM_W-1:0] new_sx;
  logic signed [SUM_W-1:0] old_sx;
  logic signed [SUM_W-1:0] sum_upd;
  logic [SAMPLE_W-1:0]     mean_val;

  assign lg      = lg_of(act_depth_ff[ch_ff]);
  assign dmask   = 6'((7'h01 << lg) - 7'h01);
  assign new_sx  = SUM_W'(signed'(smp_ff));
  assign old_sx  = SUM_W'(signed'(mem_rd));
  assign sum_upd = sum_ff[ch_ff] - old_sx + new_sx;
  assign f_ready = (st_ff == IAF_IDLE) && !unit_restart;
  // Oldest entry is read while the sample is popped
  assign mem_ra  = {f_data[18:16], ptr_ff[f_data[18:16]]};

  always_comb begin
    nxt_st     = st_ff;
    nxt_smp    = smp_ff;
    nxt_ch     = ch_ff;
    nxt_brk    = brk_ff;
    nxt_pcnt   = pcnt_ff;
    nxt_ptr    = ptr_ff;
    nxt_sum    = sum_ff;
    nxt_out    = out_ff;
    nxt_primed = primed_ff;
    nxt_disc   = disc_ff;
    mem_we     = 1'b0;
    mem_wa     = {ch_ff, ptr_ff[ch_ff]};
    mean_val   = mean_of(sum_upd, lg);
    case (st_ff)
      IAF_IDLE: begin
        if (f_valid && !unit_restart) begin
          nxt_smp = f_data[15:0];
          nxt_ch  = f_data[18:16];
          nxt_brk = f_data[19];
          nxt_st  = IAF_UPD;
        end
      end
      IAF_UPD: begin
        nxt_st          = IAF_IDLE;
        nxt_disc[ch_ff] = brk_ff;
        if (brk_ff) begin
          nxt_primed[ch_ff] = 1'b0;
          if (!peak_hold[ch_ff]) begin
            nxt_out[ch_ff] = 16'h0000;
          end
        end else if (lg == 3'h0) begin
          nxt_out[ch_ff] = smp_ff;
        end else if (!primed_ff[ch_ff]) begin
          mem_we         = 1'b1;
          mem_wa         = {ch_ff, 6'h00};
          nxt_sum[ch_ff] = new_sx <<< lg;
          nxt_out[ch_ff] = smp_ff;
          nxt_pcnt       = 6'h01;
          nxt_st         = IAF_PRIME;
        end else begin
          mem_we         = 1'b1;
          nxt_sum[ch_ff] = sum_upd;
          nxt_ptr[ch_ff] = (ptr_ff[ch_ff] + 6'h01) & dmask;
          nxt_out[ch_ff] = mean_val;
          if (peak_hold[ch_ff] && signed'(out_ff[ch_ff]) > signed'(mean_val)) begin
            nxt_out[ch_ff] = out_ff[ch_ff];
          end
        end
      end
      IAF_PRIME: begin
        mem_we   = 1'b1;
        mem_wa   = {ch_ff, pcnt_ff};
        nxt_pcnt = pcnt_ff + 6'h01;
        if (pcnt_ff == dmask) begin
          nxt_primed[ch_ff] = 1'b1;
          nxt_ptr[ch_ff]    = 6'h00;
          nxt_st            = IAF_IDLE;
        end
      end
      default: nxt_st = IAF_IDLE;
    endcase
    if (unit_restart) begin
      nxt_st     = IAF_IDLE;
      nxt_primed = '0;
      nxt_disc   = '0;
      for (int i = 0; i < N; i++) begin
        nxt_ptr[i] = 6'h00;
        nxt_out[i] = 16'h0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff     <= IAF_IDLE;
      smp_ff    <= 16'h0000;
      ch_ff     <= 3'h0;
      brk_ff    <= 1'b0;
      pcnt_ff   <= 6'h00;
      primed_ff <= '0;
      disc_ff   <= '0;
      for (int i = 0; i < N; i++) begin
        ptr_ff[i] <= 6'h00;
        sum_ff[i] <= '0;
        out_ff[i] <= 16'h0000;
      end
    end else begin
      st_ff     <= nxt_st;
      smp_ff    <= nxt_smp;
      ch_ff     <= nxt_ch;
      brk_ff    <= nxt_brk;
      pcnt_ff   <= nxt_pcnt;
      primed_ff <= nxt_primed;
      disc_ff   <= nxt_disc;
      ptr_ff    <= nxt_ptr;
      sum_ff    <= nxt_sum;
      out_ff    <= nxt_out;
    end
  end

  // Unused inputs read zero regardless of stale samples
  for (genvar c = 0; c < N; c++) begin : g_out
    assign conv_words[c*SAMPLE_W +: SAMPLE_W] = act_en_ff[c] ? out_ff[c] : 16'h0000;
  end
  assign disc_flags = disc_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_disc_zero;
    (st_ff == IAF_UPD) && brk_ff && !peak_hold[ch_ff] && !unit_restart
      |=> out_ff[ch_ff] == 16'h0000 && disc_ff[ch_ff];
  endproperty
  a_disc_zero: assert property (p_disc_zero) else $error("broken input not zero");

  property p_reprime;
    (st_ff == IAF_UPD) && brk_ff |=> !primed_ff[ch_ff];
  endproperty
  a_reprime: assert property (p_reprime) else $error("broken input kept primed");

  property p_bypass;
    (st_ff == IAF_UPD) && !brk_ff && (lg == 3'h0) && !unit_restart
      |=> out_ff[ch_ff] == $past(smp_ff) && st_ff == IAF_IDLE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass sample not forwarded");

  property p_first_mean;
    (st_ff == IAF_UPD) && !brk_ff && (lg != 3'h0) && !primed_ff[ch_ff] && !unit_restart
      |=> out_ff[ch_ff] == $past(smp_ff) && st_ff == IAF_PRIME;
  endproperty
  a_first_mean: assert property (p_first_mean) else $error("first mean not sample");

  property p_prime_done;
    $fell(st_ff == IAF_PRIME) && !$past(unit_restart) |-> primed_ff[ch_ff] && ptr_ff[ch_ff] == 6'h00;
  endproperty
  a_prime_done: assert property (p_prime_done) else $error("priming did not finish");

  property p_sum;
    (st_ff == IAF_UPD) && !brk_ff && (lg != 3'h0) && primed_ff[ch_ff] && !unit_restart
      |=> sum_ff[ch_ff] == $past(sum_ff[ch_ff]) - $past(old_sx) + $past(new_sx);
  endproperty
  a_sum: assert property (p_sum) else $error("running sum wrong");

  property p_mean;
    (st_ff == IAF_UPD) && !brk_ff && (lg != 3'h0) && primed_ff[ch_ff]
      && !peak_hold[ch_ff] && !unit_restart
      |=> out_ff[ch_ff] == mean_of(sum_ff[ch_ff], lg);
  endproperty
  a_mean: assert property (p_mean) else $error("mean not shifted sum");

  property p_hold_stable;
    !unit_restart |=> $stable(act_en_ff) && $stable(act_fast_ff);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("setup applied early");

  property p_restart_load;
    unit_restart |=> act_en_ff == $past(sh_en_ff);
  endproperty
  a_restart_load: assert property (p_restart_load) else $error("restart did not load");

  // A restart may legally pull the next request in early
  property p_req_enabled;
    conv_req |-> act_en_ff[conv_chan] ##1 (!conv_req || $past(unit_restart, 2)) [*8];
  endproperty
  a_req_enabled: assert property (p_req_enabled) else $error("bad conversion request");

  c_prime: cover property (st_ff == IAF_PRIME ##1 st_ff == IAF_IDLE);
  c_bypass: cover property ((st_ff == IAF_UPD) && !brk_ff && (lg == 3'h0));
  c_broken: cover property ((st_ff == IAF_UPD) && brk_ff);
  c_restart: cover property (unit_restart ##2 conv_req);
endmodule

/* core/iaf_hist_mem.sv */
`timescale 1ns/1ns
module iaf_hist_mem #(
  parameter int W  = 16,
  parameter int AW = 9
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic [W-1:0]       rd_data
);
  logic [W-1:0] mem_ff [2**AW];

  // ----------------------------------------------------------------
  // History storage, registered read
  // ----------------------------------------------------------------
  // Read data lag the address by one edge
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_ff[wr_addr] <= wr_data;
    end
    rd_data <= mem_ff[rd_addr];
  end
endmodule

/* include/iaf_pkg.sv */
package iaf_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_INPUTS   = 8;
  localparam int SAMPLE_W     = 16;
  localparam int MAX_LG_DEPTH = 6;
  localparam int SUM_W        = SAMPLE_W + MAX_LG_DEPTH;
  localparam int FIFO_DEPTH   = 32;

  // ----------------------------------------------------------------
  // Setup memory area word offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_INPUT_EN   = 5'h00;
  localparam logic [4:0] OFS_DEPTH_BASE = 5'h02;
  localparam logic [4:0] OFS_DEPTH_LAST = 5'h09;
  localparam logic [4:0] OFS_RATE_CFG   = 5'h12;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_INPUT_EN   = 16'h00FF;
  localparam logic [15:0] RST_DEPTH      = 16'h0000;
  localparam logic [15:0] RST_RATE_CFG   = 16'h0000;
  localparam int          RATE_FIELD_LSB = 8;
  localparam int          RATE_FIELD_MSB = 15;
  localparam logic [7:0]  RATE_FAST_CODE = 8'h01;

  // ----------------------------------------------------------------
  // Averaging depth codes
  // ----------------------------------------------------------------
  localparam logic [15:0] DEPTH_CODE_2    = 16'h0000;
  localparam logic [15:0] DEPTH_CODE_NONE = 16'h0001;
  localparam logic [15:0] DEPTH_CODE_4    = 16'h0002;
  localparam logic [15:0] DEPTH_CODE_8    = 16'h0003;
  localparam logic [15:0] DEPTH_CODE_16   = 16'h0004;
  localparam logic [15:0] DEPTH_CODE_32   = 16'h0005;
  localparam logic [15:0] DEPTH_CODE_64   = 16'h0006;

  // ----------------------------------------------------------------
  // Resolution and timing
  // ----------------------------------------------------------------
  localparam logic [13:0] FULL_SCALE_DEFAULT = 14'h0FA0;
  localparam logic [13:0] FULL_SCALE_FAST    = 14'h1F40;
  localparam int CLK_PERIOD_NS     = 50;
  localparam int CONV_T_DEFAULT_US = 1000;
  localparam int CONV_T_FAST_US    = 250;
  localparam int CONV_CYC_DEFAULT  = (CONV_T_DEFAULT_US * 1000) / CLK_PERIOD_NS;
  localparam int CONV_CYC_FAST     = (CONV_T_FAST_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {IAF_IDLE, IAF_UPD, IAF_PRIME} iaf_state_t;

endpackage

/* tb/iaf_front_model.sv */
`timescale 1ns/1ns
// Front end stand-in: one sample per conversion request
module iaf_front_model (
  input  wire logic        clk,
  input  wire logic        conv_req,
  input  wire logic [2:0]  conv_chan,
  input  wire logic [15:0] val,
  input  wire logic        brk,
  input  wire logic        s_ready,
  output logic             s_valid,
  output logic [2:0]       s_chan,
  output logic [15:0]      s_data,
  output logic             s_broken
);
  initial begin
    s_valid = 1'b0;
    s_chan = 3'h0;
    s_data = 16'h0000;
    s_broken = 1'b0;
  end
  // Held until taken; released data is inverted so stale data never looks valid
  always @(posedge clk) begin
    if (s_valid && s_ready) begin
      s_valid <= 1'b0;
      s_data <= ~s_data;
    end else if (conv_req && !s_valid) begin
      s_valid <= 1'b1;
      s_chan <= conv_chan;
      s_data <= val;
      s_broken <= brk;
    end
  end
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ns
module tb_top import iaf_pkg::*;;
  logic clk, rst_n, host_wr, host_rd, unit_restart, conv_req, conv_fast;
  logic s_valid, s_ready, s_broken, brk;
  logic [4:0] host_addr;
  logic [15:0] host_wdata, host_rdata, s_data, val;
  logic [7:0] peak_hold, disc_flags;
  logic [2:0] conv_chan, s_chan;
  logic [13:0] full_scale;
  logic [127:0] conv_words;
  int n, n_mismatch, samples_checked;

  // Short scan periods keep the run brief
  iaf_filter #(.CYC_SLOW(40), .CYC_FAST(10)) i_iaf_filter (.clk(clk), .rst_n(rst_n),
    .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rdata(host_rdata), .unit_restart(unit_restart),
    .peak_hold(peak_hold), .conv_req(conv_req), .conv_chan(conv_chan),
    .conv_fast(conv_fast), .full_scale(full_scale), .s_valid(s_valid),
    .s_ready(s_ready), .s_chan(s_chan), .s_data(s_data), .s_broken(s_broken),
    .conv_words(conv_words), .disc_flags(disc_flags));
  iaf_front_model i_iaf_front_model (.clk(clk), .conv_req(conv_req),
    .conv_chan(conv_chan), .val(val), .brk(brk), .s_ready(s_ready),
    .s_valid(s_valid), .s_chan(s_chan), .s_data(s_data), .s_broken(s_broken));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Every task starts and ends 1 ns after a rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge clk) #1 host_wr = 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clk) #1 host_rd = 1'b0;
    chk(host_rdata, exp);
    @(posedge clk) #1;
  endtask

  task automatic restart;
    unit_restart = 1'b1;
    @(posedge clk) #1 unit_restart = 1'b0;
    @(posedge clk) #1;
  endtask

  task automatic wait_req;
    n = 0;
    do begin
      @(posedge clk) #1;
      n++;
    end while (conv_req !== 1'b1 && n < 100);
  endtask

  // Output lands a few cycles after the request, well inside one period
  task automatic sample(input logic [15:0] v, input logic b, input logic [15:0] exp);
    val = v;
    brk = b;
    wait_req();
    repeat (12) @(posedge clk);
    #1 chk(conv_words[15:0], exp);
  endtask

  // Watchdog sized at several times the expected run
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    {host_wr, host_rd, unit_restart, brk, rst_n} = 5'h00;
    {host_addr, host_wdata, val, peak_hold} = '0;
    repeat (5) @(posedge clk);
    #1 rst_n = 1'b1;
    chk({2'b00, full_scale}, 16'd4000);
    chk({15'h0000, conv_fast}, 16'h0000);
    rd(OFS_DEPTH_BASE, 16'h0000);
    wait_req();
    wait_req();
    chk(n[15:0], 16'd40);
    // Round robin has reached the third input by now
    chk({13'h0000, conv_chan}, 16'h0002);
    // One enabled input, four-entry history
    wr(OFS_INPUT_EN, 16'h0001);
    wr(OFS_DEPTH_BASE, 16'h0002);
    rd(OFS_DEPTH_BASE, 16'h0002);
    // Unmapped index must not echo the previous read
    rd(5'h01, 16'h0000);
    restart();
    sample(16'hFFFB, 1'b0, 16'hFFFB);
    sample(16'h0006, 1'b0, 16'hFFFD);
    sample(16'h0010, 1'b1, 16'h0000);
    chk({15'h0000, disc_flags[0]}, 16'h0001);
    sample(16'h0008, 1'b0, 16'h0008);
    chk({15'h0000, disc_flags[0]}, 16'h0000);
    chk(conv_words[31:16], 16'h0000);
    // Held mean survives a lower mean, yields to a higher one
    peak_hold = 8'h01;
    sample(16'h0000, 1'b0, 16'h0008);
    sample(16'h0040, 1'b0, 16'h0014);
    peak_hold = 8'h00;
    // Bypass and fast setting, held back until restart
    wr(OFS_DEPTH_BASE, 16'h0001);
    wr(OFS_RATE_CFG, 16'h0100);
    chk({15'h0000, conv_fast}, 16'h0000);
    restart();
    chk({15'h0000, conv_fast}, 16'h0001);
    chk({2'b00, full_scale}, 16'd8000);
    sample(16'h0123, 1'b0, 16'h0123);
    wait_req();
    wait_req();
    chk(n[15:0], 16'd10);
    tally_and_finish();
  end
endmodule
